// *** hdl/can_iso_ctrl_pkg.sv ***
// constants for the isolated can transceiver controller
// assumes a 20 MHz core clock and a 32-bit axi4-lite register port
package can_iso_ctrl_pkg;
   localparam int CLK_HZ = 20_000_000;
   localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;
   // settle margin after the converter is switched on
   localparam int POWER_MARGIN_US = 5000;
   localparam int POWER_WAIT_CYCLES = POWER_MARGIN_US * CYCLES_PER_US;
   // least dominant-timeout period of the transceiver, plain default
   localparam int DTO_MIN_US = 1000;
   localparam int MAX_DOMINANT_BITS = 11;
   // longest bit that keeps eleven dominant bits inside the timeout (rounded down)
   localparam int MAX_BIT_CYCLES = DTO_MIN_US * CYCLES_PER_US / MAX_DOMINANT_BITS;

   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_BITDIV = 8'h04;
   localparam logic [7:0] ADDR_TXDATA = 8'h08;
   localparam logic [7:0] ADDR_TXCMD = 8'h0c;
   localparam logic [7:0] ADDR_STATUS = 8'h10;

   localparam int CTRL_ENABLE_BIT = 0;
   localparam int CTRL_NORMAL_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [15:0] BITDIV_RESET = 16'h0014;
   localparam logic [31:0] TXDATA_RESET = 32'h0000_0000;

   localparam int STAT_READY_BIT = 0;
   localparam int STAT_FAULT_BIT = 1;
   localparam int STAT_RX_LEVEL_BIT = 2;
   localparam int STAT_BUSY_BIT = 3;
   localparam int STAT_RX_EDGE_BIT = 4;
   localparam int STAT_FAULT_SEEN_BIT = 5;

   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [0:0] {TX_IDLE, TX_SHIFT} tx_state_type;
endpackage

// *** hdl/pin_sync.sv ***
// two-stage synchroniser for one pin input
// assumes the pin is asynchronous to i_core_clk; reset value chosen per instance
`timescale 1ns/1ps
module pin_sync #(
   parameter logic RESET_VAL = 1'b1
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_sync
);
   logic stage1;
   logic next_stage1;
   logic next_sync;

   always_comb begin
      next_stage1 = i_async;
      next_sync = stage1;
      if (i_rst) begin
         next_stage1 = RESET_VAL;
         next_sync = RESET_VAL;
      end
   end

   always_ff @(posedge i_core_clk) begin
      stage1 <= next_stage1;
      o_sync <= next_sync;
   end
endmodule

// *** hdl/can_iso_ctrl.sv ***
// host-side controller for an isolated can transceiver: axi4-lite registers,
// bit-serial transmit, standby select, enable/fault pin and receive monitor
// assumes the enable/fault wire has an external pull-up and rxd is asynchronous
//
// Our own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module can_iso_ctrl
   import can_iso_ctrl_pkg::*;
#(
   parameter int POWER_WAIT = POWER_WAIT_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_s_axi_awvalid,
   output logic o_s_axi_awready,
   input wire logic [7:0] i_s_axi_awaddr,
   input wire logic i_s_axi_wvalid,
   output logic o_s_axi_wready,
   input wire logic [31:0] i_s_axi_wdata,
   input wire logic [3:0] i_s_axi_wstrb,
   output logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   output logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   output logic o_s_axi_arready,
   input wire logic [7:0] i_s_axi_araddr,
   output logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   output logic [31:0] o_s_axi_rdata,
   output logic [1:0] o_s_axi_rresp,
   output logic o_txd,
   output logic o_standby_select,
   output logic o_enable_fault_out,
   output logic o_enable_fault_oe,
   input wire logic i_enable_fault_in,
   input wire logic i_rxd
);
   // bus and register state
   logic aw_held, w_held, next_aw_held, next_w_held;
   logic [7:0] waddr, next_waddr;
   logic [31:0] wdata, next_wdata;
   logic [3:0] wstrb, next_wstrb;
   logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
   logic [1:0] next_bresp, next_rresp;
   logic [31:0] next_rdata;
   logic [1:0] ctrl, next_ctrl;
   logic [15:0] bitdiv, next_bitdiv;
   logic [31:0] txdata, next_txdata;
   logic do_write, start_req;
   logic [5:0] start_len;
   logic [31:0] clear_mask;

   // link state
   tx_state_type tx_state, next_tx_state;
   logic [31:0] shift, next_shift;
   logic [5:0] bits_left, next_bits_left;
   logic [15:0] bit_cnt, next_bit_cnt;
   logic [3:0] dom_run, next_dom_run;
   logic [31:0] power_cnt, next_power_cnt;
   logic ready, next_ready;
   logic rx_prev, next_rx_prev;
   logic rx_edge, next_rx_edge;
   logic fault_seen, next_fault_seen;
   logic next_txd, next_standby, next_en_oe;
   logic rxd_s, en_pin_s;
   logic fault_now, bit_tick;
   logic [15:0] bit_period;
   logic [1:0] oe_hist, next_oe_hist;
   logic [31:0] ctrl_merged, bitdiv_merged;

   pin_sync #(.RESET_VAL(1'b1)) u_rxd_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_rxd),
      .o_sync(rxd_s)
   );

   pin_sync #(.RESET_VAL(1'b0)) u_en_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(i_enable_fault_in),
      .o_sync(en_pin_s)
   );

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data,
                                         input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[i*8 +: 8] = data[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // converter released and yet the wire reads low: the transceiver reports a fault
   // wait out the two sync stages after release, else every enable looks like a fault
   assign fault_now = ctrl[CTRL_ENABLE_BIT] && !o_enable_fault_oe && (oe_hist == 2'b00)
                      && !en_pin_s;

   assign ctrl_merged = merge({30'h0, ctrl}, wdata, wstrb);
   assign bitdiv_merged = merge({16'h0, bitdiv}, wdata, wstrb);

   // clamp so that eleven bits never outlast the least dominant timeout
   always_comb begin
      bit_period = bitdiv;
      if (bitdiv == 16'h0000) begin
         bit_period = 16'h0001;
      end else if (bitdiv > 16'(MAX_BIT_CYCLES)) begin
         bit_period = 16'(MAX_BIT_CYCLES);
      end
   end

   always_comb begin
      next_aw_held = aw_held;
      next_w_held = w_held;
      next_waddr = waddr;
      next_wdata = wdata;
      next_wstrb = wstrb;
      next_bvalid = o_s_axi_bvalid;
      next_bresp = o_s_axi_bresp;
      next_rvalid = o_s_axi_rvalid;
      next_rdata = o_s_axi_rdata;
      next_rresp = o_s_axi_rresp;
      next_ctrl = ctrl;
      next_bitdiv = bitdiv;
      next_txdata = txdata;
      start_req = 1'b0;
      start_len = wdata[5:0];
      clear_mask = 32'h0000_0000;
      do_write = aw_held && w_held && !o_s_axi_bvalid;
      if (o_s_axi_bvalid && i_s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (o_s_axi_awready && i_s_axi_awvalid) begin
         next_aw_held = 1'b1;
         next_waddr = i_s_axi_awaddr;
      end
      if (o_s_axi_wready && i_s_axi_wvalid) begin
         next_w_held = 1'b1;
         next_wdata = i_s_axi_wdata;
         next_wstrb = i_s_axi_wstrb;
      end
      if (do_write) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = RESP_OKAY;
         unique case (waddr)
            ADDR_CTRL: next_ctrl = ctrl_merged[1:0];
            ADDR_BITDIV: next_bitdiv = bitdiv_merged[15:0];
            ADDR_TXDATA: next_txdata = merge(txdata, wdata, wstrb);
            ADDR_TXCMD: start_req = wstrb[0];
            ADDR_STATUS: clear_mask = wstrb[0] ? wdata : 32'h0000_0000;
            default: next_bresp = RESP_SLVERR;
         endcase
      end
      if (o_s_axi_rvalid && i_s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (o_s_axi_arready && i_s_axi_arvalid) begin
         next_rvalid = 1'b1;
         next_rresp = RESP_OKAY;
         next_rdata = 32'h0000_0000;
         unique case (i_s_axi_araddr)
            ADDR_CTRL: next_rdata = {30'h0, ctrl};
            ADDR_BITDIV: next_rdata = {16'h0, bitdiv};
            ADDR_TXDATA: next_rdata = txdata;
            ADDR_TXCMD: next_rdata = {26'h0, bits_left};
            ADDR_STATUS: begin
               next_rdata[STAT_READY_BIT] = ready;
               next_rdata[STAT_FAULT_BIT] = fault_now;
               next_rdata[STAT_RX_LEVEL_BIT] = rxd_s;
               next_rdata[STAT_BUSY_BIT] = (tx_state == TX_SHIFT);
               next_rdata[STAT_RX_EDGE_BIT] = rx_edge;
               next_rdata[STAT_FAULT_SEEN_BIT] = fault_seen;
            end
            default: next_rresp = RESP_SLVERR;
         endcase
      end
      next_awready = !next_aw_held && !next_bvalid;
      next_wready = !next_w_held && !next_bvalid;
      next_arready = !next_rvalid;
      if (i_rst) begin
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_waddr = 8'h00;
         next_wdata = 32'h0000_0000;
         next_wstrb = 4'h0;
         next_bvalid = 1'b0;
         next_bresp = RESP_OKAY;
         next_rvalid = 1'b0;
         next_rdata = 32'h0000_0000;
         next_rresp = RESP_OKAY;
         next_ctrl = CTRL_RESET;
         next_bitdiv = BITDIV_RESET;
         next_txdata = TXDATA_RESET;
         next_awready = 1'b0;
         next_wready = 1'b0;
         next_arready = 1'b0;
      end
   end

   always_ff @(posedge i_core_clk) begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      waddr <= next_waddr;
      wdata <= next_wdata;
      wstrb <= next_wstrb;
      o_s_axi_awready <= next_awready;
      o_s_axi_wready <= next_wready;
      o_s_axi_bvalid <= next_bvalid;
      o_s_axi_bresp <= next_bresp;
      o_s_axi_arready <= next_arready;
      o_s_axi_rvalid <= next_rvalid;
      o_s_axi_rdata <= next_rdata;
      o_s_axi_rresp <= next_rresp;
      ctrl <= next_ctrl;
      bitdiv <= next_bitdiv;
      txdata <= next_txdata;
   end

   assign bit_tick = (bit_cnt == 16'h0000);

   always_comb begin
      next_tx_state = tx_state;
      next_shift = shift;
      next_bits_left = bits_left;
      next_bit_cnt = bit_cnt;
      next_dom_run = dom_run;
      next_power_cnt = power_cnt;
      next_ready = ready;
      next_rx_prev = rxd_s;
      next_oe_hist = {oe_hist[0], o_enable_fault_oe};
      next_txd = 1'b1;
      // drive the open-drain wire low only to hold the converter off
      next_en_oe = !ctrl[CTRL_ENABLE_BIT];
      next_standby = !(ctrl[CTRL_NORMAL_BIT] && ready);
      // a fresh event beats a software clear in the same cycle
      next_rx_edge = (rx_edge && !clear_mask[STAT_RX_EDGE_BIT]) || (rx_prev && !rxd_s);
      next_fault_seen = (fault_seen && !clear_mask[STAT_FAULT_SEEN_BIT]) || fault_now;
      // converter off or faulted restarts the settle wait
      if (!ctrl[CTRL_ENABLE_BIT] || fault_now) begin
         next_power_cnt = 32'h0000_0000;
         next_ready = 1'b0;
      end else if (!ready) begin
         if (power_cnt >= 32'(POWER_WAIT - 1)) begin
            next_ready = 1'b1;
         end else begin
            next_power_cnt = power_cnt + 32'h0000_0001;
         end
      end
      unique case (tx_state)
         TX_IDLE: begin
            next_dom_run = 4'h0;
            if (start_req && start_len != 6'h00 && ready && ctrl[CTRL_NORMAL_BIT]) begin
               next_tx_state = TX_SHIFT;
               next_shift = txdata;
               next_bits_left = start_len;
               next_bit_cnt = bit_period - 16'h0001;
               // low on the transmit pin is a dominant bit
               next_txd = txdata[0];
               next_dom_run = txdata[0] ? 4'h0 : 4'h1;
            end
         end
         TX_SHIFT: begin
            next_txd = o_txd;
            if (bit_tick) begin
               next_bit_cnt = bit_period - 16'h0001;
               next_shift = {1'b1, shift[31:1]};
               next_bits_left = bits_left - 6'h01;
               if (bits_left == 6'h01) begin
                  next_tx_state = TX_IDLE;
                  next_txd = 1'b1;
                  next_bits_left = 6'h00;
               end else if (!shift[1] && dom_run < 4'(MAX_DOMINANT_BITS)) begin
                  next_txd = 1'b0;
                  next_dom_run = dom_run + 4'h1;
               end else begin
                  // an overlong dominant run is broken by a forced recessive bit
                  next_txd = 1'b1;
                  next_dom_run = 4'h0;
               end
            end else begin
               next_bit_cnt = bit_cnt - 16'h0001;
            end
            // losing power or normal mode ends the frame recessive
            if (!ready || !ctrl[CTRL_NORMAL_BIT]) begin
               next_tx_state = TX_IDLE;
               next_txd = 1'b1;
               next_bits_left = 6'h00;
            end
         end
      endcase
      if (i_rst) begin
         next_tx_state = TX_IDLE;
         next_shift = 32'h0000_0000;
         next_bits_left = 6'h00;
         next_bit_cnt = 16'h0000;
         next_dom_run = 4'h0;
         next_power_cnt = 32'h0000_0000;
         next_ready = 1'b0;
         next_rx_prev = 1'b1;
         next_oe_hist = 2'b11;
         next_rx_edge = 1'b0;
         next_fault_seen = 1'b0;
         next_txd = 1'b1;
         next_en_oe = 1'b1;
         next_standby = 1'b1;
      end
   end

   always_ff @(posedge i_core_clk) begin
      tx_state <= next_tx_state;
      shift <= next_shift;
      bits_left <= next_bits_left;
      bit_cnt <= next_bit_cnt;
      dom_run <= next_dom_run;
      power_cnt <= next_power_cnt;
      ready <= next_ready;
      rx_prev <= next_rx_prev;
      oe_hist <= next_oe_hist;
      rx_edge <= next_rx_edge;
      fault_seen <= next_fault_seen;
      // push-pull transmit keeps bit edges sharp without a pull-up
      o_txd <= next_txd;
      o_standby_select <= next_standby;
      o_enable_fault_oe <= next_en_oe;
      o_enable_fault_out <= 1'b0;
   end
endmodule

// *** bench/can_iso_ctrl_assertions.sv ***
// port-level checks on the isolated can transceiver controller
// assumes it is bound to can_iso_ctrl and sees only that module's ports
`timescale 1ns/1ps
module can_iso_ctrl_assertions
   import can_iso_ctrl_pkg::*;
#(
   parameter int POWER_WAIT = POWER_WAIT_CYCLES
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_s_axi_awvalid,
   input wire logic o_s_axi_awready,
   input wire logic i_s_axi_wvalid,
   input wire logic o_s_axi_wready,
   input wire logic o_s_axi_bvalid,
   input wire logic i_s_axi_bready,
   input wire logic [1:0] o_s_axi_bresp,
   input wire logic i_s_axi_arvalid,
   input wire logic o_s_axi_arready,
   input wire logic o_s_axi_rvalid,
   input wire logic i_s_axi_rready,
   input wire logic [31:0] o_s_axi_rdata,
   input wire logic o_txd,
   input wire logic o_standby_select,
   input wire logic o_enable_fault_out,
   input wire logic o_enable_fault_oe,
   input wire logic i_enable_fault_in
);
   localparam int DTO_CYC = DTO_MIN_US * CYCLES_PER_US;
   int run, next_run, up, next_up;
   // saturate so the enable counter never wraps on long runs
   always_comb begin
      next_run = o_txd ? 0 : run + 1;
      next_up = o_enable_fault_oe ? 0 : ((up < POWER_WAIT + 8) ? up + 1 : up);
   end
   always_ff @(posedge i_core_clk) begin
      run <= i_rst ? 0 : next_run;
      up <= i_rst ? 0 : next_up;
   end
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_rst);
   property p_dom_run; !o_txd |-> run < DTO_CYC; endproperty
   a_dom_run: assert property (p_dom_run) else $error("dominant run too long");
   property p_ready_wait; !o_standby_select |-> up >= POWER_WAIT; endproperty
   a_ready_wait: assert property (p_ready_wait) else $error("normal mode too early");
   property p_fault_off;
      (!o_enable_fault_oe && !i_enable_fault_in) [*3] |-> ##[0:6] o_standby_select;
   endproperty
   a_fault_off: assert property (p_fault_off) else $error("fault kept normal mode");
   property p_od_low; !o_enable_fault_out; endproperty
   a_od_low: assert property (p_od_low) else $error("enable pin driven high");
   property p_stb_txd; o_standby_select && $past(o_standby_select) |-> o_txd; endproperty
   a_stb_txd: assert property (p_stb_txd) else $error("dominant in standby");
   property p_wr_lat;
      i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid && o_s_axi_wready
         |=> ##1 o_s_axi_bvalid;
   endproperty
   a_wr_lat: assert property (p_wr_lat) else $error("write response late");
   property p_rd_lat; i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid; endproperty
   a_rd_lat: assert property (p_rd_lat) else $error("read data late");
   property p_b_hold;
      o_s_axi_bvalid && !i_s_axi_bready |=> o_s_axi_bvalid && $stable(o_s_axi_bresp);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write response dropped");
   property p_r_hold;
      o_s_axi_rvalid && !i_s_axi_rready |=> o_s_axi_rvalid && $stable(o_s_axi_rdata);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read data dropped");
endmodule

bind can_iso_ctrl can_iso_ctrl_assertions #(.POWER_WAIT(POWER_WAIT)) u_chk (
   .i_core_clk(i_core_clk), .i_rst(i_rst), .i_s_axi_awvalid(i_s_axi_awvalid),
   .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wvalid(i_s_axi_wvalid),
   .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bvalid(o_s_axi_bvalid),
   .i_s_axi_bready(i_s_axi_bready), .o_s_axi_bresp(o_s_axi_bresp),
   .i_s_axi_arvalid(i_s_axi_arvalid), .o_s_axi_arready(o_s_axi_arready),
   .o_s_axi_rvalid(o_s_axi_rvalid), .i_s_axi_rready(i_s_axi_rready),
   .o_s_axi_rdata(o_s_axi_rdata), .o_txd(o_txd), .o_standby_select(o_standby_select),
   .o_enable_fault_out(o_enable_fault_out), .o_enable_fault_oe(o_enable_fault_oe),
   .i_enable_fault_in(i_enable_fault_in));

// *** bench/can_xcvr_model.sv ***
// behavioural isolated transceiver seen from the controller's pins
// assumes the core clock as time base; faults and remote traffic come from the bench
`timescale 1ns/1ps
module can_xcvr_model #(
   parameter int DTO_CYCLES = 20000,
   parameter int SOFT_START = 8
) (
   input wire logic i_core_clk,
   input wire logic i_txd,
   input wire logic i_standby_select,
   input wire logic i_enable_fault_wire,
   input wire logic i_fault,
   input wire logic i_remote_dom,
   output logic o_rxd,
   output logic o_fault_pull
);
   logic txd, stb, iso_good, bus_dom;
   logic txd_q = 1'b1;
   logic dominant_timeout = 1'b0;
   int ss = 0;
   int dcnt = 0;
   assign txd = (i_txd !== 1'b0);
   assign stb = (i_standby_select !== 1'b0);
   // supply, overvoltage and thermal faults all end as a low pull on the wire
   assign o_fault_pull = i_fault;
   always @(posedge i_core_clk) begin
      txd_q <= txd;
      if (!i_enable_fault_wire) ss <= 0;
      else if (ss < SOFT_START) ss <= ss + 1;
      if (txd) begin
         dcnt <= 0;
         dominant_timeout <= 1'b0;
      end else if (txd_q) begin
         dcnt <= 1;
      end else if (dcnt >= DTO_CYCLES) begin
         dominant_timeout <= 1'b1;
      end else begin
         dcnt <= dcnt + 1;
      end
   end
   assign iso_good = (ss >= SOFT_START);
   assign bus_dom = iso_good && !stb && !txd && !dominant_timeout;
   assign o_rxd = !iso_good || stb || !(bus_dom || i_remote_dom);
endmodule

// *** bench/testbench.sv ***
// self-checking bench for the isolated can transceiver controller
// assumes the transceiver model on the far side; the enable/fault wire is pulled up here
`timescale 1ns/1ps
module testbench;
   import can_iso_ctrl_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, txd, stb, en_out, en_oe, rxd, pull;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata, d;
   logic [3:0] wstrb = 4'hf;
   logic [1:0] bresp, rresp, r;
   logic fault = 1'b0, remote = 1'b0, txd_q = 1'b1;
   int num_errors = 0, n_checks = 0, lowc = 0, run = 0, maxrun = 0, falls = 0;
   wire en_wire = !(en_oe && !en_out) && !pull;
   initial begin
      forever #25 clk = ~clk;
   end
   can_iso_ctrl #(.POWER_WAIT(20)) DUT (.i_core_clk(clk), .i_rst(rst),
      .i_s_axi_awvalid(awvalid), .o_s_axi_awready(awready), .i_s_axi_awaddr(awaddr),
      .i_s_axi_wvalid(wvalid), .o_s_axi_wready(wready), .i_s_axi_wdata(wdata),
      .i_s_axi_wstrb(wstrb), .o_s_axi_bvalid(bvalid), .i_s_axi_bready(bready),
      .o_s_axi_bresp(bresp), .i_s_axi_arvalid(arvalid), .o_s_axi_arready(arready),
      .i_s_axi_araddr(araddr), .o_s_axi_rvalid(rvalid), .i_s_axi_rready(rready),
      .o_s_axi_rdata(rdata), .o_s_axi_rresp(rresp), .o_txd(txd), .o_standby_select(stb),
      .o_enable_fault_out(en_out), .o_enable_fault_oe(en_oe),
      .i_enable_fault_in(en_wire), .i_rxd(rxd));
   can_xcvr_model XCVR (.i_core_clk(clk), .i_txd(txd), .i_standby_select(stb),
      .i_enable_fault_wire(en_wire), .i_fault(fault), .i_remote_dom(remote),
      .o_rxd(rxd), .o_fault_pull(pull));
   always @(posedge clk) begin
      txd_q <= txd;
      if (txd === 1'b0) begin
         lowc <= lowc + 1;
         run <= run + 1;
         if (run + 1 > maxrun) maxrun <= run + 1;
         if (txd_q) falls <= falls + 1;
      end else begin
         run <= 0;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic chkb(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
      logic aw_ok;
      logic w_ok;
      @(posedge clk);
      awvalid <= 1'b1;
      awaddr <= a;
      wvalid <= 1'b1;
      wdata <= v;
      bready <= 1'b1;
      aw_ok = 1'b0;
      w_ok = 1'b0;
      while (!(aw_ok && w_ok)) begin
         @(posedge clk);
         aw_ok = aw_ok || (awready === 1'b1);
         w_ok = w_ok || (wready === 1'b1);
         if (aw_ok) awvalid <= 1'b0;
         if (w_ok) wvalid <= 1'b0;
      end
      do @(posedge clk); while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge clk);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge clk); while (rvalid !== 1'b1);
      v = rdata;
      rs = rresp;
      rready <= 1'b0;
   endtask
   // counters cleared only while txd idles, so the monitor never writes them too
   task automatic send(input logic [31:0] div, input logic [31:0] dat, input logic [31:0] n);
      int i;
      @(posedge clk);
      lowc <= 0;
      maxrun <= 0;
      falls <= 0;
      wr(ADDR_BITDIV, div, r);
      wr(ADDR_TXDATA, dat, r);
      wr(ADDR_TXCMD, n, r);
      i = 0;
      do begin
         rd(ADDR_STATUS, d, r);
         i++;
      end while (d[STAT_BUSY_BIT] !== 1'b0 && i < 200);
      chkb(d[STAT_BUSY_BIT], 1'b0);
      @(posedge clk);
   endtask
   task automatic t_reset();
      chkb(en_oe, 1'b1);
      chkb(stb, 1'b1);
      chkb(txd, 1'b1);
      rd(ADDR_CTRL, d, r);
      chk(d, 32'h0000_0000);
      rd(ADDR_BITDIV, d, r);
      chk(d, 32'h0000_0014);
      rd(ADDR_STATUS, d, r);
      chk(d, 32'h0000_0004);
      wr(8'h20, 32'h0000_0001, r);
      chk({30'h0, r}, {30'h0, RESP_SLVERR});
      rd(8'h20, d, r);
      chk({r, d[29:0]}, {RESP_SLVERR, 30'h0});
      $display("t_reset done");
   endtask
   task automatic t_power();
      int i;
      wr(ADDR_CTRL, 32'h0000_0003, r);
      // the enable output moves one edge after the write lands
      repeat (2) @(posedge clk);
      chkb(en_oe, 1'b0);
      chkb(stb, 1'b1);
      i = 0;
      do begin
         rd(ADDR_STATUS, d, r);
         i++;
      end while (d[STAT_READY_BIT] !== 1'b1 && i < 100);
      repeat (2) @(posedge clk);
      chkb(stb, 1'b0);
      chk(d & 32'h0000_002f, 32'h0000_0005);
      $display("t_power done");
   endtask
   task automatic t_tx();
      send(32'h0000_0002, 32'h0000_000a, 32'h0000_0004);
      chk(32'(lowc), 32'h0000_0004);
      chk(32'(falls), 32'h0000_0002);
      rd(ADDR_STATUS, d, r);
      chkb(d[STAT_RX_EDGE_BIT], 1'b1);
      send(32'h0000_0000, 32'h0000_0000, 32'h0000_0001);
      chk(32'(lowc), 32'h0000_0001);
      send(32'h0000_0003, 32'h0000_0000, 32'h0000_000c);
      chk(32'(maxrun), 32'h0000_0021);
      chk(32'(lowc), 32'h0000_0021);
      remote <= 1'b1;
      repeat (4) @(posedge clk);
      rd(ADDR_STATUS, d, r);
      chkb(d[STAT_RX_LEVEL_BIT], 1'b0);
      remote <= 1'b0;
      $display("t_tx done");
   endtask
   task automatic t_fault();
      fault <= 1'b1;
      repeat (8) @(posedge clk);
      chkb(stb, 1'b1);
      rd(ADDR_STATUS, d, r);
      chk(d & 32'h0000_0023, 32'h0000_0022);
      fault <= 1'b0;
      wr(ADDR_STATUS, 32'h0000_0030, r);
      rd(ADDR_STATUS, d, r);
      chk(d & 32'h0000_0022, 32'h0000_0000);
      wr(ADDR_CTRL, 32'h0000_0000, r);
      repeat (2) @(posedge clk);
      chkb(en_oe, 1'b1);
      chkb(stb, 1'b1);
      send(32'h0000_0002, 32'h0000_0000, 32'h0000_0004);
      chk(32'(lowc), 32'h0000_0000);
      chkb(d[STAT_RX_LEVEL_BIT], 1'b1);
      $display("t_fault done");
   endtask
   task automatic results();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1_000_000;
      num_errors++;
      results();
   end
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      t_reset();
      t_power();
      t_tx();
      t_fault();
      results();
   end
endmodule
